// File: rtl/frame_cmd_host.sv
// Host end of the framed command link: serialises one command, then,
// except after leave, collects the reply frame and hands it to the user side.
// Assumes the module end shares SYS_CLK and honours valid/ready.
`default_nettype none

module frame_cmd_host
  import frame_cmd_pkg::*;
(
  input  wire logic         SYS_CLK,
  input  wire logic         RST_B,
  frame_link_if.host        LINK,
  input  wire logic         CMD_VALID,
  output var  logic         CMD_READY,
  input  wire logic [7:0]   CMD_TYPE,
  input  wire logic [7:0]   CMD_ARG0,
  input  wire logic [7:0]   CMD_ARG1,
  input  wire logic [7:0]   CMD_ARG2,
  input  wire logic [127:0] CMD_VALUE,
  output var  logic         RSP_VALID,
  output var  logic [7:0]   RSP_TYPE,
  output var  logic [7:0]   RSP_LEN,
  output var  logic [7:0]   RSP_ARG,
  output var  logic [127:0] RSP_VALUE
);

  typedef enum logic [2:0] {
    HS_IDLE, HS_SEND, HS_HUNT, HS_LEN, HS_BODY
  } host_state_e;

  host_state_e state_ff;
  host_state_e nxt_state;
  logic [7:0]   type_ff, a0_ff, a1_ff, a2_ff;
  logic [127:0] value_ff;
  logic [7:0]   idx_ff;
  logic         tx_valid_ff;
  logic [7:0]   tx_data_ff;
  logic         rx_ready_ff;
  logic         cmd_ready_ff;
  logic [7:0]   rlen_ff;
  logic [7:0]   rcnt_ff;
  logic         rsp_valid_ff;
  logic [7:0]   rsp_type_ff;
  logic [7:0]   rsp_arg_ff;
  logic [127:0] rsp_value_ff;

  // ---------------------------------------------------------------
  // Command byte selection
  // ---------------------------------------------------------------
  wire [7:0] cmd_len =
      (type_ff == ENTER_FRAMED_CMD)   ? ENTER_LEN
    : (type_ff == MODULE_RESTART_CMD) ? RESTART_LEN
    : (type_ff == PARAM_READ_CMD)     ? READ_LEN
    : (type_ff == PARAM_WRITE_CMD)    ? a2_ff + WRITE_HDR
    : LEAVE_LEN;
  wire [7:0] arg_idx = idx_ff - ARG_POS;
  wire [7:0] val_idx = idx_ff - VALUE_POS;
  wire [7:0] key_b   = ENTER_KEY[{arg_idx[2:0], 3'b000} +: 8];
  wire [7:0] fld_b   = (arg_idx == 8'h00) ? a0_ff
                     : (arg_idx == 8'h01) ? a1_ff : a2_ff;
  wire [7:0] tx_byte =
      (idx_ff == 8'h00) ? FRAME_START_BYTE
    : (idx_ff == 8'h01) ? cmd_len
    : (idx_ff == 8'h02) ? type_ff
    : (type_ff == ENTER_FRAMED_CMD) ? key_b
    : (idx_ff < VALUE_POS) ? fld_b
    : value_ff[{val_idx[3:0], 3'b000} +: 8];
  wire       tx_free = !tx_valid_ff || LINK.h2d_ready;
  wire       tx_done = tx_free && idx_ff >= cmd_len + LEN_OVERHEAD;
  wire       rx_take = LINK.d2h_valid && rx_ready_ff;
  wire       rx_last = rx_take && rcnt_ff + 8'h01 == rlen_ff;
  wire [7:0] rv_idx  = rcnt_ff - 8'h04;

  // ---------------------------------------------------------------
  // Sequencer; the leave command expects no reply
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      HS_IDLE: if (CMD_VALID && cmd_ready_ff) nxt_state = HS_SEND;
      HS_SEND: begin
        if (tx_done) begin
          nxt_state = (type_ff == LEAVE_FRAMED_CMD) ? HS_IDLE : HS_HUNT;
        end
      end
      HS_HUNT: begin
        if (rx_take && LINK.d2h_data == FRAME_START_BYTE) begin
          nxt_state = HS_LEN;
        end
      end
      HS_LEN: begin
        if (rx_take) begin
          nxt_state = (LINK.d2h_data == 8'h00) ? HS_HUNT : HS_BODY;
        end
      end
      HS_BODY: if (rx_last) nxt_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_ff     <= HS_IDLE;
      cmd_ready_ff <= 1'b0;
      rx_ready_ff  <= 1'b0;
      type_ff      <= 8'h00;
      a0_ff        <= 8'h00;
      a1_ff        <= 8'h00;
      a2_ff        <= 8'h00;
      value_ff     <= '0;
    end else begin
      state_ff     <= nxt_state;
      cmd_ready_ff <= nxt_state == HS_IDLE;
      rx_ready_ff  <= nxt_state == HS_HUNT || nxt_state == HS_LEN
                   || nxt_state == HS_BODY;
      if (state_ff == HS_IDLE && CMD_VALID && cmd_ready_ff) begin
        type_ff  <= CMD_TYPE;
        a0_ff    <= CMD_ARG0;
        a1_ff    <= CMD_ARG1;
        a2_ff    <= CMD_ARG2;
        value_ff <= CMD_VALUE;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      idx_ff      <= 8'h00;
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
    end else if (state_ff != HS_SEND) begin
      idx_ff      <= 8'h00;
      tx_valid_ff <= 1'b0;
    end else if (tx_free) begin
      tx_valid_ff <= !tx_done;
      if (!tx_done) begin
        tx_data_ff <= tx_byte;
        idx_ff     <= idx_ff + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Reply capture, value bytes packed low byte first
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rlen_ff      <= 8'h00;
      rcnt_ff      <= 8'h00;
      rsp_valid_ff <= 1'b0;
      rsp_type_ff  <= 8'h00;
      rsp_arg_ff   <= 8'h00;
      rsp_value_ff <= '0;
    end else begin
      rsp_valid_ff <= state_ff == HS_BODY && rx_last;
      if (state_ff == HS_LEN && rx_take) begin
        rlen_ff      <= LINK.d2h_data;
        rcnt_ff      <= 8'h00;
        rsp_value_ff <= '0;
      end else if (state_ff == HS_BODY && rx_take) begin
        rcnt_ff <= rcnt_ff + 8'h01;
        if (rcnt_ff == 8'h00) begin
          rsp_type_ff <= LINK.d2h_data;
        end
        if (rcnt_ff == 8'h01) begin
          rsp_arg_ff <= LINK.d2h_data;
        end
        if (rcnt_ff >= 8'h04 && rv_idx < 8'h10) begin
          rsp_value_ff[{rv_idx[3:0], 3'b000} +: 8] <= LINK.d2h_data;
        end
      end
    end
  end

  assign LINK.h2d_valid = tx_valid_ff;
  assign LINK.h2d_data  = tx_data_ff;
  assign LINK.d2h_ready = rx_ready_ff;
  assign CMD_READY      = cmd_ready_ff;
  assign RSP_VALID      = rsp_valid_ff;
  assign RSP_TYPE       = rsp_type_ff;
  assign RSP_LEN        = rlen_ff;
  assign RSP_ARG        = rsp_arg_ff;
  assign RSP_VALUE      = rsp_value_ff;

endmodule : frame_cmd_host

`default_nettype wire

// File: rtl/frame_cmd_parser.sv
// Module end of the framed command link: frames host bytes, decodes the
// local command set, keeps the parameter store and sends replies.
// Assumes the host end shares SYS_CLK and honours valid/ready.
//
// Functional notes
// R1: Every frame opens with start byte.
// R2: Enter: type 0x00, length 7, key.
// R3: Enter accepted: reply start, 0x01, 0x10.
// R4: Leave: type 0x01, length 1, no reply.
// R5: Restart: type 0x02, length 2, target.
// R6: Restart targets 0..2; acknowledge with 0x12.
// R7: Read: type 0x03, length 4, offset/bank/size.
// R8: Size must match parameter, else error.
// R9: Read reply 0x13 echoes fields, then value.
// R10: Malformed read returns error message.
// R11: Write: type 0x04, fields, then value.
// R12: Length counts bytes after itself.
// R13: Reply type is command type plus bit 4.
// R14: Multi-byte values least significant first.
// R15: Hunt start byte, then collect length bytes.
`default_nettype none

module frame_cmd_parser
  import frame_cmd_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  frame_link_if.device     LINK,
  output var  logic        FRAMED_MODE,
  output var  logic        RESTART_REQ,
  output var  logic [1:0]  RESTART_TARGET,
  output var  logic        FORMAT_ERROR
);

  typedef enum logic [2:0] {
    ST_HUNT, ST_LEN, ST_BODY, ST_EXEC, ST_SEND
  } rx_state_e;

  typedef enum logic [2:0] {
    REP_NONE, REP_ENTER, REP_RESTART, REP_READ, REP_WRITE, REP_ERROR
  } reply_e;

  rx_state_e   state_ff;
  reply_e      reply_ff;
  reply_e      nxt_reply;
  logic [7:0]  rx_buf_ff [0:BODY_BYTES-1];
  logic [7:0]  cfg_mem_ff [0:NUM_BANKS-1][0:BANK_BYTES-1];
  logic [7:0]  rx_cnt_ff;
  logic [7:0]  rx_len_ff;
  logic [7:0]  tx_idx_ff;
  logic        tx_valid_ff;
  logic [7:0]  tx_data_ff;
  logic        rx_ready_ff;
  logic        framed_ff;
  logic        restart_ff;
  logic [1:0]  target_ff;
  logic        error_ff;

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  wire        rx_take  = LINK.h2d_valid && rx_ready_ff;
  wire [7:0]  cmd_type = rx_buf_ff[0];
  wire [7:0]  p_off    = rx_buf_ff[1];
  wire [7:0]  p_bank   = rx_buf_ff[2];
  wire [7:0]  p_size   = rx_buf_ff[3];
  wire [1:0]  bank_sel = p_bank[1:0];
  wire [3:0]  off_sel  = p_off[3:0];
  wire [7:0]  true_sz  = BANK_PSIZE[{bank_sel, 3'b000} +: 8];
  wire [47:0] key_rx   = {rx_buf_ff[6], rx_buf_ff[5], rx_buf_ff[4],
                          rx_buf_ff[3], rx_buf_ff[2], rx_buf_ff[1]};
  wire        key_ok   = key_rx == ENTER_KEY;
  wire        len_bad  = rx_len_ff > MAX_LEN;
  wire        addr_ok  = (p_bank < 8'(NUM_BANKS))
                         && (p_off < 8'(BANK_BYTES))
                         && ((p_off & (true_sz - 8'h01)) == 8'h00)
                         && (p_size == true_sz); // R8
  wire        tgt_ok   = rx_buf_ff[1] <= RESTART_RADIO; // R6
  wire [7:0]  wr_len   = p_size + WRITE_HDR;

  // Command selection; outside framed mode only enter is honoured
  always_comb begin
    nxt_reply = REP_ERROR;
    if (len_bad) begin
      nxt_reply = REP_ERROR;
    end else if (cmd_type == ENTER_FRAMED_CMD) begin
      if (rx_len_ff == ENTER_LEN && key_ok) begin // R2
        nxt_reply = REP_ENTER;
      end
    end else if (!framed_ff) begin
      nxt_reply = REP_NONE;
    end else begin
      unique case (cmd_type)
        LEAVE_FRAMED_CMD: begin
          if (rx_len_ff == LEAVE_LEN) begin // R4
            nxt_reply = REP_NONE;
          end
        end
        MODULE_RESTART_CMD: begin
          if (rx_len_ff == RESTART_LEN && tgt_ok) begin // R5
            nxt_reply = REP_RESTART;
          end
        end
        PARAM_READ_CMD: begin
          if (rx_len_ff == READ_LEN && addr_ok) begin // R7 R10
            nxt_reply = REP_READ;
          end
        end
        PARAM_WRITE_CMD: begin
          if (rx_len_ff == wr_len && addr_ok) begin // R11
            nxt_reply = REP_WRITE;
          end
        end
        default: nxt_reply = REP_ERROR;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Reply byte selection
  // ---------------------------------------------------------------
  wire [7:0] rep_len = (reply_ff == REP_READ)  ? READ_LEN + true_sz
                     : (reply_ff == REP_ERROR) ? ERROR_LEN
                     : ACK_LEN;
  wire [7:0] tx_total = rep_len + LEN_OVERHEAD; // R12
  wire [7:0] rep_type = (reply_ff == REP_ERROR) ? ERROR_MSG_TYPE
                      : (cmd_type | REPLY_FLAG); // R13
  wire [7:0] val_idx  = tx_idx_ff - VALUE_POS;
  wire [3:0] val_addr = off_sel + val_idx[3:0];
  wire [7:0] tx_byte  =
      (tx_idx_ff == 8'h00) ? FRAME_START_BYTE // R1
    : (tx_idx_ff == 8'h01) ? rep_len
    : (tx_idx_ff == 8'h02) ? rep_type
    : (tx_idx_ff == ARG_POS && reply_ff == REP_ERROR) ? cmd_type
    : (tx_idx_ff < VALUE_POS) ? rx_buf_ff[tx_idx_ff[1:0] - 2'd2]
    : cfg_mem_ff[bank_sel][val_addr]; // R9 R14
  wire       tx_free  = !tx_valid_ff || LINK.d2h_ready;
  wire       tx_done  = tx_free && (tx_idx_ff >= tx_total);

  // ---------------------------------------------------------------
  // Frame state machine
  // ---------------------------------------------------------------
  rx_state_e nxt_state;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_HUNT: begin
        if (rx_take && LINK.h2d_data == FRAME_START_BYTE) begin // R15
          nxt_state = ST_LEN;
        end
      end
      ST_LEN: begin
        if (rx_take) begin
          nxt_state = (LINK.h2d_data == 8'h00) ? ST_HUNT : ST_BODY;
        end
      end
      ST_BODY: begin
        if (rx_take && rx_cnt_ff + 8'h01 == rx_len_ff) begin // R15
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: nxt_state = (nxt_reply == REP_NONE) ? ST_HUNT : ST_SEND;
      ST_SEND: nxt_state = tx_done ? ST_HUNT : ST_SEND;
    endcase
  end

  wire rx_open = nxt_state == ST_HUNT || nxt_state == ST_LEN
              || nxt_state == ST_BODY;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_ff    <= ST_HUNT;
      rx_ready_ff <= 1'b0;
      rx_cnt_ff   <= 8'h00;
      rx_len_ff   <= 8'h00;
      reply_ff    <= REP_NONE;
    end else begin
      state_ff    <= nxt_state;
      rx_ready_ff <= rx_open;
      if (state_ff == ST_LEN && rx_take) begin
        rx_len_ff <= LINK.h2d_data; // R12
        rx_cnt_ff <= 8'h00;
      end else if (state_ff == ST_BODY && rx_take) begin
        rx_cnt_ff <= rx_cnt_ff + 8'h01;
      end
      if (state_ff == ST_EXEC) begin
        reply_ff <= nxt_reply;
      end
    end
  end

  // Body bytes past the first BODY_BYTES are counted out but not stored
  always_ff @(posedge SYS_CLK) begin
    if (state_ff == ST_BODY && rx_take && rx_cnt_ff < 8'(BODY_BYTES)) begin
      rx_buf_ff[rx_cnt_ff[4:0]] <= LINK.h2d_data;
    end
  end

  // ---------------------------------------------------------------
  // Parameter store and command effects
  // ---------------------------------------------------------------
  wire do_write = state_ff == ST_EXEC && nxt_reply == REP_WRITE;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        for (int i = 0; i < BANK_BYTES; i++) begin
          cfg_mem_ff[b][i] <= CFG_RESET;
        end
      end
    end else if (do_write) begin
      for (int i = 0; i < BANK_BYTES; i++) begin
        if (8'(i) < p_size) begin
          cfg_mem_ff[bank_sel][off_sel + 4'(i)] <= rx_buf_ff[i + 4]; // R14
        end
      end
    end
  end

  wire exec = state_ff == ST_EXEC;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      framed_ff  <= 1'b0;
      restart_ff <= 1'b0;
      target_ff  <= 2'b00;
      error_ff   <= 1'b0;
    end else begin
      if (exec && nxt_reply == REP_ENTER) begin
        framed_ff <= 1'b1;
      end else if (exec && framed_ff && cmd_type == LEAVE_FRAMED_CMD
                   && rx_len_ff == LEAVE_LEN && !len_bad) begin // R4
        framed_ff <= 1'b0;
      end
      restart_ff <= exec && nxt_reply == REP_RESTART; // R6
      if (exec && nxt_reply == REP_RESTART) begin
        target_ff <= rx_buf_ff[1][1:0];
      end
      error_ff <= exec && nxt_reply == REP_ERROR;
    end
  end

  // ---------------------------------------------------------------
  // Reply transmitter
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_idx_ff   <= 8'h00;
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
    end else if (state_ff != ST_SEND) begin
      tx_idx_ff   <= 8'h00;
      tx_valid_ff <= 1'b0;
    end else if (tx_free) begin
      tx_valid_ff <= !tx_done;
      if (!tx_done) begin
        tx_data_ff <= tx_byte; // R3 R9
        tx_idx_ff  <= tx_idx_ff + 8'h01;
      end
    end
  end

  assign LINK.h2d_ready = rx_ready_ff;
  assign LINK.d2h_valid = tx_valid_ff;
  assign LINK.d2h_data  = tx_data_ff;
  assign FRAMED_MODE    = framed_ff;
  assign RESTART_REQ    = restart_ff;
  assign RESTART_TARGET = target_ff;
  assign FORMAT_ERROR   = error_ff;

endmodule : frame_cmd_parser

`default_nettype wire

// File: rtl/frame_cmd_pkg.sv
// Shared constants for the framed command link: framing bytes, type
// codes, lengths, parameter map and reset values.
// Assumes both link ends run on one clock and reset.
`default_nettype none

package frame_cmd_pkg;

  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  localparam logic [7:0] FRAME_START_BYTE = 8'hFB;
  localparam logic [7:0] LEN_OVERHEAD     = 8'h02;
  localparam logic [7:0] MAX_LEN          = 8'h20;
  localparam int         BODY_BYTES       = 32;
  localparam logic [7:0] REPLY_FLAG       = 8'h10;
  localparam logic [7:0] EVENT_FLAG       = 8'h20;

  // ---------------------------------------------------------------
  // Message types
  // ---------------------------------------------------------------
  localparam logic [7:0] ENTER_FRAMED_CMD   = 8'h00;
  localparam logic [7:0] LEAVE_FRAMED_CMD   = 8'h01;
  localparam logic [7:0] MODULE_RESTART_CMD = 8'h02;
  localparam logic [7:0] PARAM_READ_CMD     = 8'h03;
  localparam logic [7:0] PARAM_WRITE_CMD    = 8'h04;
  localparam logic [7:0] ERROR_MSG_TYPE     = 8'h27;

  // ---------------------------------------------------------------
  // Lengths and field offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ENTER_LEN   = 8'h07;
  localparam logic [7:0] LEAVE_LEN   = 8'h01;
  localparam logic [7:0] RESTART_LEN = 8'h02;
  localparam logic [7:0] READ_LEN    = 8'h04;
  localparam logic [7:0] ACK_LEN     = 8'h01;
  localparam logic [7:0] ERROR_LEN   = 8'h02;
  localparam logic [7:0] WRITE_HDR   = 8'h04;
  localparam logic [7:0] VALUE_POS   = 8'h06;
  localparam logic [7:0] ARG_POS     = 8'h03;

  // Key carried by the enter command, low byte first
  localparam logic [47:0] ENTER_KEY = 48'h4746_4354_4E44;

  // ---------------------------------------------------------------
  // Restart targets
  // ---------------------------------------------------------------
  localparam logic [7:0] RESTART_NORMAL = 8'h00;
  localparam logic [7:0] RESTART_SERIAL = 8'h01;
  localparam logic [7:0] RESTART_RADIO  = 8'h02;

  // ---------------------------------------------------------------
  // Parameter map: 4 banks of 16 bytes, one size per bank
  // ---------------------------------------------------------------
  localparam int         NUM_BANKS  = 4;
  localparam int         BANK_BYTES = 16;
  localparam logic [31:0] BANK_PSIZE = 32'h1004_0201;
  localparam logic [7:0] CFG_RESET  = 8'h00;

endpackage : frame_cmd_pkg

`default_nettype wire

// File: rtl/frame_link_if.sv
// Byte link between host controller and module parser.
// Each direction is a valid/ready byte stream on the shared clock.
`default_nettype none

interface frame_link_if;
  logic       h2d_valid;
  logic [7:0] h2d_data;
  logic       h2d_ready;
  logic       d2h_valid;
  logic [7:0] d2h_data;
  logic       d2h_ready;

  modport device (
    input  h2d_valid,
    input  h2d_data,
    output h2d_ready,
    output d2h_valid,
    output d2h_data,
    input  d2h_ready
  );

  modport host (
    output h2d_valid,
    output h2d_data,
    input  h2d_ready,
    input  d2h_valid,
    input  d2h_data,
    output d2h_ready
  );
endinterface : frame_link_if

`default_nettype wire

// File: test/frame_link_properties.sv
// Concurrent checks on the byte link between host end and module parser.
// Assumes one clock, async active-low reset and well-formed host frames.
`default_nettype none

module frame_link_properties
  import frame_cmd_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       RST_B,
  input wire logic       h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_ready,
  input wire logic       d2h_valid,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_ready
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Frame position trackers
  // ---------------------------------------------------------------
  logic [7:0] hpos_ff, hlen_ff, htype_ff, dpos_ff, dlen_ff;
  logic [7:0] nxt_hpos, nxt_dpos, last_type;
  logic       h_take, d_take, h_last, d_last;

  assign h_take = h2d_valid & h2d_ready;
  assign d_take = d2h_valid & d2h_ready;
  assign h_last = h_take & (hpos_ff >= 8'h02) & (hpos_ff == hlen_ff + 8'h01);
  assign d_last = d_take & (dpos_ff >= 8'h02) & (dpos_ff == dlen_ff + 8'h01);
  // Type byte may arrive on the very edge that closes the frame
  assign last_type = (hpos_ff == 8'h02) ? h2d_data : htype_ff;
  assign nxt_hpos = !h_take ? hpos_ff : h_last ? 8'h00 :
                    (hpos_ff == 8'h00 && h2d_data != FRAME_START_BYTE) ?
                    8'h00 : hpos_ff + 8'h01;
  assign nxt_dpos = !d_take ? dpos_ff : d_last ? 8'h00 : dpos_ff + 8'h01;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hpos_ff  <= 8'h00;
      hlen_ff  <= 8'h00;
      htype_ff <= 8'h00;
      dpos_ff  <= 8'h00;
      dlen_ff  <= 8'h00;
    end else begin
      hpos_ff  <= nxt_hpos;
      dpos_ff  <= nxt_dpos;
      hlen_ff  <= (h_take && hpos_ff == 8'h01) ? h2d_data : hlen_ff;
      htype_ff <= (h_take && hpos_ff == 8'h02) ? h2d_data : htype_ff;
      dlen_ff  <= (d_take && dpos_ff == 8'h01) ? d2h_data : dlen_ff;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_cmd_hold: assert property (h2d_valid && !h2d_ready |=>
    h2d_valid && $stable(h2d_data)) else $error("host byte dropped early");
  a_reply_hold: assert property (d2h_valid && !d2h_ready |=>
    d2h_valid && $stable(d2h_data)) else $error("reply byte dropped early");
  a_cmd_sop: assert property (h_take && hpos_ff == 8'h00 |->
    h2d_data == FRAME_START_BYTE) else $error("command lacks start byte");
  a_reply_sop: assert property (d2h_valid && dpos_ff == 8'h00 |->
    d2h_data == FRAME_START_BYTE) else $error("reply lacks start byte");
  a_reply_type: assert property (d2h_valid && dpos_ff == 8'h02 |->
    d2h_data == (htype_ff | REPLY_FLAG) || d2h_data == ERROR_MSG_TYPE)
    else $error("reply type does not echo command");
  a_reply_len: assert property (d2h_valid && dpos_ff == 8'h01 |->
    d2h_data == ERROR_LEN || ((htype_ff == PARAM_READ_CMD) ?
    (d2h_data >= 8'h05 && d2h_data <= MAX_LEN) : d2h_data == ACK_LEN))
    else $error("reply length out of range");
  a_enter_len: assert property (h_take && hpos_ff == 8'h02 &&
    h2d_data == ENTER_FRAMED_CMD |-> hlen_ff == ENTER_LEN)
    else $error("enter command length wrong");
  a_read_len: assert property (h_take && hpos_ff == 8'h02 &&
    h2d_data == PARAM_READ_CMD |-> hlen_ff == READ_LEN)
    else $error("read command length wrong");
  a_write_len: assert property (h_take && hpos_ff == 8'h02 &&
    h2d_data == PARAM_WRITE_CMD |-> hlen_ff >= 8'h05 && hlen_ff <= MAX_LEN)
    else $error("write command length wrong");
  a_ready_drop: assert property (h_last &&
    last_type != LEAVE_FRAMED_CMD |-> ##2 !h2d_ready)
    else $error("parser still accepting during execution");
  a_reply_soon: assert property (h_last &&
    last_type != LEAVE_FRAMED_CMD |-> ##[2:3] d2h_valid)
    else $error("reply not started in time");
endmodule : frame_link_properties

`default_nettype wire

// File: test/tb_serial_local_command_parser.sv
// Testbench joining host end and module parser over the byte link.
// Assumes 50 MHz SYS_CLK; stimulus lands 1 ns after each rising edge.
`default_nettype none

module tb_serial_local_command_parser
  import frame_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic         sys_clk = 1'b0, rst_b = 1'b0;
  logic         cmd_valid = 1'b0, cmd_ready, rsp_valid;
  logic [7:0]   cmd_type = 8'h00, arg0 = 8'h00, arg1 = 8'h00, arg2 = 8'h00;
  logic [127:0] cmd_value = '0, rsp_value, val, mask;
  logic [7:0]   rsp_type, rsp_len, rsp_arg, sz, off;
  logic         framed_mode, restart_req, format_error;
  logic [1:0]   restart_target;
  int           bad_count = 0, total_checks = 0, req_seen = 0, err_seen = 0;

  always #10 sys_clk = ~sys_clk;

  frame_link_if link ();
  frame_cmd_parser frame_cmd_parser_i (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .LINK(link), .FRAMED_MODE(framed_mode), .RESTART_REQ(restart_req),
    .RESTART_TARGET(restart_target), .FORMAT_ERROR(format_error));
  frame_cmd_host frame_cmd_host_i (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .LINK(link), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_TYPE(cmd_type), .CMD_ARG0(arg0), .CMD_ARG1(arg1), .CMD_ARG2(arg2),
    .CMD_VALUE(cmd_value), .RSP_VALID(rsp_valid), .RSP_TYPE(rsp_type),
    .RSP_LEN(rsp_len), .RSP_ARG(rsp_arg), .RSP_VALUE(rsp_value));
  frame_link_properties frame_link_properties_i (.SYS_CLK(sys_clk),
    .RST_B(rst_b), .h2d_valid(link.h2d_valid), .h2d_data(link.h2d_data),
    .h2d_ready(link.h2d_ready), .d2h_valid(link.d2h_valid),
    .d2h_data(link.d2h_data), .d2h_ready(link.d2h_ready));

  // Pulse outputs last one cycle, so count them at every edge
  always @(posedge sys_clk) begin
    if (restart_req === 1'b1) req_seen++;
    if (format_error === 1'b1) err_seen++;
  end

  // ---------------------------------------------------------------
  // Compare and access tasks
  // ---------------------------------------------------------------
  task automatic fail(input logic [127:0] got, exp);
    bad_count++;
    $display("mismatch t=%0t got %h exp %h", $time, got, exp);
  endtask : fail

  task automatic chk_byte(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) fail(got, exp);
  endtask : chk_byte

  task automatic chk_value(input logic [127:0] got, exp);
    total_checks++;
    if (got !== exp) fail(got, exp);
  endtask : chk_value

  task automatic chk_flag(input logic got, exp);
    total_checks++;
    if (got !== exp) fail(got, exp);
  endtask : chk_flag

  // Entered 1 ns after an edge; returns 1 ns after an edge
  task automatic send(input logic [7:0] t, a0, a1, a2,
                      input logic [127:0] v, input bit want);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmd_type = t;
    arg0 = a0;
    arg1 = a1;
    arg2 = a2;
    cmd_value = v;
    cmd_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    while (want && rsp_valid !== 1'b1 && n < 500) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 500) fail(n, 0);
  endtask : send

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Whole sequence needs a few hundred cycles; allow ample margin
  initial begin
    #(20000 * 20);
    bad_count++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    send(ENTER_FRAMED_CMD, 8'h00, 8'h00, 8'h00, {80'h0, ENTER_KEY}, 1);
    chk_byte(rsp_type, 8'h10);
    chk_byte(rsp_len, 8'h01);
    chk_flag(framed_mode, 1'b1);
    for (int t = 0; t < 3; t++) begin
      send(MODULE_RESTART_CMD, t[7:0], 8'h00, 8'h00, '0, 1);
      chk_byte(rsp_type, 8'h12);
      chk_byte({6'h00, restart_target}, t[7:0]);
      chk_byte(req_seen[7:0], 8'(t + 1));
    end
    // Never written parameter still holds its reset value
    send(PARAM_READ_CMD, 8'h04, 8'h02, 8'h04, '0, 1);
    chk_byte(rsp_len, 8'h08);
    chk_value(rsp_value, 128'h0);
    // Top aligned offset of each bank, full width value
    for (int b = 0; b < NUM_BANKS; b++) begin
      sz = BANK_PSIZE[8*b +: 8];
      off = 8'h10 - sz;
      mask = (sz == 8'h10) ? '1 : ((128'h1 << (8 * sz)) - 128'h1);
      val = {4{32'hA5C3_0F17 + 32'(b)}} & mask;
      send(PARAM_WRITE_CMD, off, b[7:0], sz, val, 1);
      chk_byte(rsp_type, 8'h14);
      chk_byte(rsp_len, 8'h01);
      send(PARAM_READ_CMD, off, b[7:0], sz, '0, 1);
      chk_byte(rsp_type, 8'h13);
      chk_byte(rsp_len, 8'h04 + sz);
      chk_byte(rsp_arg, off);
      chk_value(rsp_value, val);
    end
    // Wrong size, then misaligned offset
    for (int e = 0; e < 2; e++) begin
      send(PARAM_READ_CMD, e[7:0], 8'h01, 8'h01 + e[7:0], '0, 1);
      chk_byte(rsp_type, ERROR_MSG_TYPE);
      chk_byte(rsp_len, ERROR_LEN);
      chk_byte(rsp_arg, PARAM_READ_CMD);
      chk_byte(err_seen[7:0], 8'(e + 1));
    end
    send(LEAVE_FRAMED_CMD, 8'h00, 8'h00, 8'h00, '0, 0);
    for (int n = 0; n < 100 && framed_mode !== 1'b0; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk_flag(framed_mode, 1'b0);
    send(ENTER_FRAMED_CMD, 8'h00, 8'h00, 8'h00, {80'h0, ENTER_KEY}, 1);
    chk_byte(rsp_type, 8'h10);
    chk_flag(framed_mode, 1'b1);
    report_and_stop();
  end
endmodule : tb_serial_local_command_parser

`default_nettype wire
